// *** seep_regs.vh ***
// constants for the two-wire serial eeprom slave
`ifndef SEEP_REGS_VH
`define SEEP_REGS_VH
`define SEEP_DEV_CODE 4'ha
`define SEEP_CLK_NS 8
`define SEEP_PROG_MS 8
`define SEEP_PROG_CYC ((`SEEP_PROG_MS * 1000000) / `SEEP_CLK_NS)
`define SEEP_PAGE_BYTES 8
`define SEEP_ERASED 8'hff
`endif

// *** seep_mem.v ***
// byte-wide array with registered read data
`timescale 1ns/1ps
module seep_mem #(
   parameter AW = 8
) (
   input wire clk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [7:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [7:0] rdata
);
   reg [7:0] mem [0:(1<<AW)-1];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// *** seep_top.v ***
// two-wire serial eeprom slave: protocol, address counter, page buffer, programming
//
// Behaviour
// - command upper nibble 1010, b0 selects read
// - ack write command on ninth clock
// - byte after write command loads address
// - increment address after each acked data
// - stop after write data starts programming
// - erase selected bytes, then write buffer
// - programming ends within 8 ms
// - collect one to eight page bytes
// - only A0..A2 increment, wrap in page
// - unwritten page bytes untouched
// - no command ack while programming
// - address stays at last entered byte
// - repeated start cancels pending write
// - read ack, shift byte, increment address
// - current read uses address counter
// - master ack continues next byte
// - 256-byte wraps to 0, 128 does not
// - nine clocks per byte, msb first
// - start/stop while clock high
// - write protect blocks array changes
`timescale 1ns/1ps
`include "seep_regs.vh"
module seep_top #(
   parameter AW = 8,
   parameter PROG_CYCLES = `SEEP_PROG_CYC
) (
   input wire REF_CLK,
   input wire RST_N,
   input wire SCL,
   input wire SDA_IN,
   output wire SDA_OUT,
   output wire SDA_OE_N,
   input wire WP,
   output wire BUSY
);
   localparam ST_IDLE = 3'd0;
   localparam ST_CMD = 3'd1;
   localparam ST_ADDR = 3'd2;
   localparam ST_WDATA = 3'd3;
   localparam ST_RDATA = 3'd4;
   localparam ST_MACK = 3'd5;
   localparam ST_IGNORE = 3'd6;
   localparam PS_IDLE = 2'd0;
   localparam PS_ERASE = 2'd1;
   localparam PS_WRITE = 2'd2;
   localparam PS_WAIT = 2'd3;
   localparam [AW-1:0] ADDR_MAX = {AW{1'b1}};

   // two-stage synchronisers for the pins: bit 0 clock, bit 1 data, bit 2 protect
   localparam [2:0] PIN_IDLE = 3'b011;
   wire [2:0] pin_in = {WP, SDA_IN, SCL};
   wire [2:0] pin_s;
   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : g_sync
         reg meta_reg;
         reg sync_reg;
         always @(posedge REF_CLK) begin
            if (!RST_N) begin
               meta_reg <= PIN_IDLE[p];
               sync_reg <= PIN_IDLE[p];
            end else begin
               meta_reg <= pin_in[p];
               sync_reg <= meta_reg;
            end
         end
         assign pin_s[p] = sync_reg;
      end
   endgenerate

   // edge detectors rest at the idle high level so reset makes no false edge
   reg scl_d_reg;
   reg sda_d_reg;
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= pin_s[0];
         sda_d_reg <= pin_s[1];
      end
   end
   wire scl_s = pin_s[0];
   wire sda_s = pin_s[1];
   wire wp_s = pin_s[2];
   wire scl_rise = scl_s & ~scl_d_reg;
   wire scl_fall = ~scl_s & scl_d_reg;
   wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   reg [2:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] shift_reg;
   reg [AW-1:0] addr_reg;
   reg sda_low_reg;
   reg ack_phase_reg;
   reg [8*`SEEP_PAGE_BYTES-1:0] page_buf_reg;
   reg [`SEEP_PAGE_BYTES-1:0] page_sel_reg;
   reg [AW-1:0] page_base_reg;
   reg [1:0] prog_state_reg;
   reg [2:0] prog_idx_reg;
   reg [31:0] prog_cnt_reg;
   reg load_rd_reg;
   reg [7:0] tx_reg;

   wire busy = (prog_state_reg != PS_IDLE);
   wire prog_done = (prog_state_reg == PS_WAIT) && (prog_cnt_reg == 32'd0);
   wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
   wire [AW-1:0] addr_inc = (addr_reg == ADDR_MAX && AW < 8) ? addr_reg :
                            addr_reg + {{(AW-1){1'b0}}, 1'b1};
   wire [AW-1:0] page_inc = {addr_reg[AW-1:3], addr_reg[2:0] + 3'd1};
   wire [7:0] mem_rdata;

   // protocol engine: bits sampled on scl rise, driven on scl fall
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         addr_reg <= {AW{1'b0}};
         sda_low_reg <= 1'b0;
         ack_phase_reg <= 1'b0;
         page_base_reg <= {AW{1'b0}};
         load_rd_reg <= 1'b0;
         tx_reg <= 8'h00;
      end else begin
         load_rd_reg <= 1'b0;
         if (load_rd_reg) begin
            tx_reg <= mem_rdata;
         end
         if (start_det) begin
            // repeated start drops collected page data unless a programming cycle is running
            state_reg <= ST_CMD;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            sda_low_reg <= 1'b0;
         end else if (stop_det) begin
            state_reg <= ST_IDLE;
            sda_low_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
         end else if (state_reg == ST_IDLE || state_reg == ST_IGNORE) begin
            sda_low_reg <= 1'b0;
         end else if (scl_rise) begin
            if (ack_phase_reg) begin
               if (state_reg == ST_MACK) begin
                  // master ack continues, nack waits for stop
                  state_reg <= sda_s ? ST_IGNORE : ST_RDATA;
               end
            end else begin
               shift_reg <= rx_byte;
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end else if (scl_fall) begin
            if (ack_phase_reg) begin
               ack_phase_reg <= 1'b0;
               bit_cnt_reg <= 4'h0;
               sda_low_reg <= 1'b0;
               if (state_reg == ST_RDATA) begin
                  sda_low_reg <= ~tx_reg[7];
               end
            end else if (bit_cnt_reg == 4'h8) begin
               case (state_reg)
                  ST_CMD: begin
                     if (shift_reg[7:4] == `SEEP_DEV_CODE && !busy) begin
                        sda_low_reg <= 1'b1;
                        ack_phase_reg <= 1'b1;
                        state_reg <= shift_reg[0] ? ST_RDATA : ST_ADDR;
                        load_rd_reg <= 1'b1;
                     end else begin
                        state_reg <= ST_IGNORE;
                     end
                  end
                  ST_ADDR: begin
                     addr_reg <= shift_reg[AW-1:0];
                     page_base_reg <= shift_reg[AW-1:0];
                     sda_low_reg <= 1'b1;
                     ack_phase_reg <= 1'b1;
                     state_reg <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     page_base_reg <= addr_reg;
                     addr_reg <= page_inc;
                     sda_low_reg <= 1'b1;
                     ack_phase_reg <= 1'b1;
                  end
                  ST_RDATA: begin
                     sda_low_reg <= 1'b0;
                     ack_phase_reg <= 1'b1;
                     addr_reg <= addr_inc;
                     state_reg <= ST_MACK;
                  end
                  default: begin
                     state_reg <= ST_IGNORE;
                  end
               endcase
            end else if (state_reg == ST_RDATA && bit_cnt_reg != 4'h0) begin
               sda_low_reg <= ~tx_reg[7 - bit_cnt_reg[2:0]];
            end
         end
         if (state_reg == ST_MACK && scl_rise && ack_phase_reg && !sda_s) begin
            load_rd_reg <= 1'b1;
         end
         if (prog_done) begin
            // counter rests on last entered byte
            addr_reg <= page_base_reg;
         end
      end
   end

   // first bit of a read byte goes out at the ack falling edge; later bits at each fall
   wire prog_go = stop_det && state_reg == ST_WDATA && (|page_sel_reg) && !busy;
   wire buf_load = scl_fall && !ack_phase_reg && (bit_cnt_reg == 4'h8) &&
                   (state_reg == ST_WDATA);
   // a start while idle drops collected page data; polling starts during a cycle keep it
   wire sel_clear = prog_done || (start_det && !busy);
   wire [`SEEP_PAGE_BYTES-1:0] page_sel_next;
   wire [8*`SEEP_PAGE_BYTES-1:0] page_buf_next;

   // page buffer slots; a later byte for a slot overwrites the earlier one
   genvar g;
   generate
      for (g = 0; g < `SEEP_PAGE_BYTES; g = g + 1) begin : g_slot
         localparam integer SLOT = g;
         wire hit = buf_load && ({29'd0, addr_reg[2:0]} == SLOT);
         assign page_buf_next[8*g +: 8] = hit ? shift_reg : page_buf_reg[8*g +: 8];
         assign page_sel_next[g] = sel_clear ? 1'b0 : (hit | page_sel_reg[g]);
      end
   endgenerate

   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         page_buf_reg <= {(8*`SEEP_PAGE_BYTES){1'b0}};
         page_sel_reg <= {`SEEP_PAGE_BYTES{1'b0}};
      end else begin
         page_buf_reg <= page_buf_next;
         page_sel_reg <= page_sel_next;
      end
   end

   // write protect is taken once per cycle so a pin change cannot tear a page
   reg wp_lock_reg;
   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         wp_lock_reg <= 1'b0;
      end else if (prog_go) begin
         wp_lock_reg <= wp_s;
      end
   end

   reg [1:0] prog_state_next;
   reg [2:0] prog_idx_next;
   reg [31:0] prog_cnt_next;

   // programming sequencer: erase pass then write pass, then hold out the full time
   always @* begin
      prog_state_next = prog_state_reg;
      prog_idx_next = prog_idx_reg;
      prog_cnt_next = prog_cnt_reg;
      case (prog_state_reg)
         PS_IDLE: begin
            prog_idx_next = 3'd0;
            if (prog_go) begin
               prog_state_next = PS_ERASE;
               // two eight-cycle passes plus wait count and last cycle make the full time
               prog_cnt_next = PROG_CYCLES - 32'd17;
            end
         end
         PS_ERASE: begin
            prog_idx_next = prog_idx_reg + 3'd1;
            if (prog_idx_reg == 3'd7) begin
               prog_state_next = PS_WRITE;
            end
         end
         PS_WRITE: begin
            prog_idx_next = prog_idx_reg + 3'd1;
            if (prog_idx_reg == 3'd7) begin
               prog_state_next = PS_WAIT;
            end
         end
         PS_WAIT: begin
            if (prog_cnt_reg == 32'd0) begin
               prog_state_next = PS_IDLE;
            end else begin
               prog_cnt_next = prog_cnt_reg - 32'd1;
            end
         end
         default: begin
            prog_state_next = PS_IDLE;
         end
      endcase
   end

   always @(posedge REF_CLK) begin
      if (!RST_N) begin
         prog_state_reg <= PS_IDLE;
         prog_idx_reg <= 3'd0;
         prog_cnt_reg <= 32'd0;
      end else begin
         prog_state_reg <= prog_state_next;
         prog_idx_reg <= prog_idx_next;
         prog_cnt_reg <= prog_cnt_next;
      end
   end

   wire in_pass = (prog_state_reg == PS_ERASE) || (prog_state_reg == PS_WRITE);
   wire mem_we = in_pass && page_sel_reg[prog_idx_reg] && !wp_lock_reg;
   wire [7:0] mem_wdata = (prog_state_reg == PS_ERASE) ? `SEEP_ERASED :
                          page_buf_reg[8*prog_idx_reg +: 8];
   wire [AW-1:0] mem_waddr = {page_base_reg[AW-1:3], prog_idx_reg};

   seep_mem #(
      .AW(AW)
   ) u_mem (
      .clk(REF_CLK),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(addr_reg),
      .rdata(mem_rdata)
   );

   // open drain: only ever pull low
   assign SDA_OUT = 1'b0;
   assign SDA_OE_N = ~sda_low_reg;
   assign BUSY = busy;
endmodule

// *** seep_assertions.sv ***
// pin-level checks of the eeprom slave
`timescale 1ns/1ps
module seep_assertions #(
   parameter PROG_CYCLES = 100
) (
   input logic REF_CLK,
   input logic RST_N,
   input logic SCL,
   input logic SDA_IN,
   input logic SDA_OUT,
   input logic SDA_OE_N,
   input logic WP,
   input logic BUSY
);
   logic [31:0] bcnt_reg;
   always_ff @(posedge REF_CLK) begin
      bcnt_reg <= (!RST_N || !BUSY) ? 32'h0 : bcnt_reg + 32'h1;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   sequence start_cond;
      SCL && $past(SCL) && $fell(SDA_IN);
   endsequence
   a_drain_only: assert property (SDA_OUT == 1'b0)
      else $error("sda drive value not low");
   a_busy_silent: assert property (BUSY |-> SDA_OE_N)
      else $error("pull while busy");
   a_prog_bound: assert property (bcnt_reg <= PROG_CYCLES)
      else $error("busy too long");
   a_prog_end: assert property ($fell(BUSY) |-> bcnt_reg >= PROG_CYCLES - 1)
      else $error("busy too short");
   a_busy_on_stop: assert property ($rose(BUSY) |-> SCL && SDA_IN && $past(SCL, 3))
      else $error("busy without stop");
   a_oe_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL)
      else $error("sda change with scl high");
   a_ack_late: assert property ($fell(SDA_OE_N) |-> !$past(SCL, 2))
      else $error("pull too soon after scl fall");
   a_start_free: assert property (start_cond |-> SDA_OE_N)
      else $error("pull at start");
endmodule
bind seep_top seep_assertions #(.PROG_CYCLES(PROG_CYCLES)) seep_assertions_i (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .SCL(SCL), .SDA_IN(SDA_IN),
   .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .WP(WP), .BUSY(BUSY));

// *** seep_master.sv ***
// bit-level two-wire bus master, 125 ns bit period
`timescale 1ns/1ps
module seep_master (
   output logic scl,
   output logic sda,
   input logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic bit_io(input logic b, output logic r);
      #31 sda = b;
      #31.5 scl = 1'b1;
      r = sda_wire;
      #62.5 scl = 1'b0;
   endtask
   task automatic start;
      #31 sda = 1'b1;
      #31 scl = 1'b1;
      #62 sda = 1'b0;
      #62 scl = 1'b0;
   endtask
   task automatic stop;
      #31 sda = 1'b0;
      #31 scl = 1'b1;
      #62 sda = 1'b1;
      #62;
   endtask
   // ack low keeps a read going, high ends it
   task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
         output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(ack, a);
   endtask
endmodule

// *** testbench.sv ***
// write, page, read and protect traffic on the eeprom slave
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic scl, sda_m, ak;
   logic [7:0] q;
   wire sda_out, sda_oe_n, busy;
   wire sda_w = sda_m & (sda_oe_n | sda_out);
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   // rows: address, written data, expected read
   logic [23:0] rows [4] = '{24'h005a5a, 24'hffa5a5, 24'h370000, 24'h123c3c};
   seep_top #(.PROG_CYCLES(400)) seep_top_i (.REF_CLK(ref_clk), .RST_N(rst_n),
      .SCL(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
      .WP(wp), .BUSY(busy));
   seep_master seep_master_i (.scl(scl), .sda(sda_m), .sda_wire(sda_w));
   always #4 ref_clk = ~ref_clk;
   task automatic stop_test;
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c, input logic exp_ack);
      seep_master_i.start();
      seep_master_i.xfer(c, 1'b1, q, ak);
      `CHK(ak, exp_ack)
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
      cmd(8'ha0, 1'b0);
      seep_master_i.xfer(a, 1'b1, q, ak);
      `CHK(ak, 1'b0)
      foreach (d[i]) begin
         seep_master_i.xfer(d[i], 1'b1, q, ak);
         `CHK(ak, 1'b0)
      end
      seep_master_i.stop();
      repeat (8) @(negedge ref_clk);
      `CHK(busy, 1'b1)
      n = 0;
      ak = 1'b1;
      // poll with a write command so an ack needs no read-out
      while (ak && n < 40) begin
         seep_master_i.start();
         seep_master_i.xfer(8'ha0, 1'b1, q, ak);
         n++;
      end
      `CHK(n > 1, 1'b1)
      `CHK(ak, 1'b0)
      seep_master_i.stop();
   endtask
   task automatic rd(input logic set, input logic [7:0] a, input logic [7:0] e[$]);
      if (set) begin
         cmd(8'ha0, 1'b0);
         seep_master_i.xfer(a, 1'b1, q, ak);
      end
      cmd(8'ha1, 1'b0);
      foreach (e[i]) begin
         seep_master_i.xfer(8'hff, i == e.size() - 1, q, ak);
         `CHK(q, e[i])
      end
      seep_master_i.stop();
      repeat (8) @(negedge ref_clk);
      `CHK(busy, 1'b0)
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK(sda_oe_n, 1'b1)
      `CHK(busy, 1'b0)
      @(posedge ref_clk) rst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      foreach (rows[i]) begin
         wr(rows[i][23:16], {rows[i][15:8]});
         rd(1'b1, rows[i][23:16], {rows[i][7:0]});
      end
      wr(8'h16, {8'hc1, 8'hc2, 8'hc3, 8'hc4});
      rd(1'b0, 8'h00, {8'hc4});
      rd(1'b1, 8'h10, {8'hc3, 8'hc4, 8'h3c});
      rd(1'b1, 8'h16, {8'hc1, 8'hc2});
      cmd(8'ha0, 1'b0);
      seep_master_i.xfer(8'h11, 1'b1, q, ak);
      seep_master_i.xfer(8'h99, 1'b1, q, ak);
      rd(1'b0, 8'h00, {8'h3c});
      wr(8'h12, {8'h3c});
      rd(1'b1, 8'h11, {8'hc4});
      rd(1'b1, 8'hff, {8'ha5, 8'h5a});
      cmd(8'hb0, 1'b1);
      seep_master_i.stop();
      @(posedge ref_clk) wp <= 1'b1;
      wr(8'h00, {8'h77});
      @(posedge ref_clk) wp <= 1'b0;
      rd(1'b1, 8'h00, {8'h5a});
      stop_test();
   end
endmodule
